// ==== hw/autoneg_nextpage_msctl_regs.sv ====
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
// Function
// (RULE1) Parallel detection fault latches expansion bit 4
// (RULE2) Bit 3 shows partner next-page ability
// (RULE3) Bit 2 shows local next-page ability
// (RULE4) Page received latches expansion bit 1
// (RULE5) Bit 0 shows partner negotiation ability
// (RULE6) Transmit page control bits are software writable
// (RULE7) Toggle bits are read-only, flip per page
// (RULE8) Transmit code field writable, resets to one
// (RULE9) Receive page word is read-only partner copy
// (RULE10) Message-page bit selects message or unformatted
// (RULE11) Three-bit test mode field, reserved codes refused
// (RULE12) Software warned: test modes with two masters
// (RULE13) Bit 12 enables manual role configuration
// (RULE14) Bit 11 manual role, active while enable 0
// (RULE15) Bit 10 port type, active while enable 0
// (RULE16) Bit 9 advertises gigabit full duplex
// (RULE17) Bit 8 advertises gigabit half duplex
// (RULE18) Bits 12:8 default from mode strap pins
// (RULE19) Local device has no next-page support
// (RULE20) Partner gigabit ability valid with page received
// (RULE21) Latched bits clear after read returns them
// (RULE22) Reserved bits read zero, writes ignored
module autoneg_nextpage_msctl_regs
    import autoneg_regs_pkg::*;
#(
    parameter int unsigned ADDR_W = 8,
    parameter bit NP_ABLE_LOCAL = 1'b0
) (
    input wire logic clk,                          // 20 MHz clock.
    input wire logic rst_n,                        // Asynchronous reset.
    input wire logic [ADDR_W-1:0] awaddr,          // Write address.
    input wire logic awvalid,                      // Write address valid.
    output logic awready,                          // Write address ready.
    input wire logic [31:0] wdata,                 // Write data.
    input wire logic [3:0] wstrb,                  // Write strobes.
    input wire logic wvalid,                       // Write data valid.
    output logic wready,                           // Write data ready.
    output logic [1:0] bresp,                      // Write response.
    output logic bvalid,                           // Write response valid.
    input wire logic bready,                       // Write response ready.
    input wire logic [ADDR_W-1:0] araddr,          // Read address.
    input wire logic arvalid,                      // Read address valid.
    output logic arready,                          // Read address ready.
    output logic [31:0] rdata,                     // Read data.
    output logic [1:0] rresp,                      // Read response.
    output logic rvalid,                           // Read data valid.
    input wire logic rready,                       // Read data ready.
    input wire logic [1:0] mode_config_pins,       // Mode strap pins.
    input wire logic par_det_fault,                // Parallel detection fault.
    input wire logic lp_next_page_able,            // Partner next-page ability.
    input wire logic lp_autoneg_able,              // Partner negotiation ability.
    input wire logic page_received,                // New page pulse.
    input wire logic [15:0] rx_page_word,          // Received page word.
    input wire logic tx_page_sent,                 // Local page sent pulse.
    output logic [15:0] tx_page_word,              // Page word to send.
    output logic [2:0] test_mode,                  // Active test mode.
    output logic manual_enable,                    // Manual role enable.
    output logic manual_master,                    // Manual role value.
    output logic multiport,                        // Port type.
    output logic adv_1000_fd,                      // Advertise gigabit full duplex.
    output logic adv_1000_hd,                      // Advertise gigabit half duplex.
    output logic lp_ability_valid                  // Partner gigabit bits valid.
);

    if (ADDR_W < 8) begin : gen_addr_check
        $error("ADDR_W must be at least 8");
    end

    // ==========================================================
    // Bus handshake: address and data are taken together.
    logic awready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    wire wr_take = awvalid & wvalid & awready_reg;
    wire rd_take = arvalid & arready_reg;
    wire [7:0] wa = awaddr[7:0];
    wire [7:0] ra = araddr[7:0];
    wire wa_high_zero = (awaddr >> 8) == '0;
    wire ra_high_zero = (araddr >> 8) == '0;
    wire wr_np_tx = wr_take & wa_high_zero & (wa == ADDR_NP_TX);
    wire wr_ctl = wr_take & wa_high_zero & (wa == ADDR_ROLE_TEST);
    wire wr_hit = wr_take & wa_high_zero & (wa == ADDR_EXPANSION || wa == ADDR_NP_TX ||
                                            wa == ADDR_NP_RX || wa == ADDR_ROLE_TEST);
    wire rd_exp = rd_take & ra_high_zero & (ra == ADDR_EXPANSION);
    wire rd_hit = ra_high_zero & (ra == ADDR_EXPANSION || ra == ADDR_NP_TX ||
                                  ra == ADDR_NP_RX || ra == ADDR_ROLE_TEST);
    wire awready_next = awvalid & wvalid & ~awready_reg & ~bvalid_reg;
    wire bvalid_next = wr_take | (bvalid_reg & ~bready);
    wire arready_next = arvalid & ~arready_reg & ~rvalid_reg;
    wire rvalid_next = rd_take | (rvalid_reg & ~rready);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
        end else begin
            awready_reg <= awready_next;
            bvalid_reg <= bvalid_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            if (wr_take) begin
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (rd_take) begin
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // Strap capture: two-stage sync, loaded once after release.
    logic [1:0] strap_meta_reg, strap_sync_reg, settle_reg;
    logic strap_done_reg;
    wire strap_load = ~strap_done_reg & (settle_reg == STRAP_LOAD_CYCLE);
    wire [4:0] strap_value = (strap_sync_reg == 2'h0) ? STRAP_MODE0 :
                             (strap_sync_reg == 2'h1) ? STRAP_MODE1 :
                             (strap_sync_reg == 2'h2) ? STRAP_MODE2 : STRAP_MODE3;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta_reg <= 2'h0;
            strap_sync_reg <= 2'h0;
            settle_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else begin
            strap_meta_reg <= mode_config_pins;
            strap_sync_reg <= strap_meta_reg;
            if (!strap_done_reg) begin
                settle_reg <= settle_reg + 2'h1;
            end
            if (strap_load) begin
                strap_done_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Expansion status: latched and live bits.
    logic pd_fault_reg, page_rx_reg, lp_np_reg, lp_an_reg;
    wire pd_fault_next = par_det_fault | (pd_fault_reg & ~rd_exp);   // see (RULE1) see (RULE21)
    wire page_rx_next = page_received | (page_rx_reg & ~rd_exp);     // see (RULE4) see (RULE21)

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_fault_reg <= 1'b0;
            page_rx_reg <= 1'b0;
            lp_np_reg <= 1'b0;
            lp_an_reg <= 1'b0;
        end else begin
            pd_fault_reg <= pd_fault_next;
            page_rx_reg <= page_rx_next;
            lp_np_reg <= lp_next_page_able;                           // see (RULE2)
            lp_an_reg <= lp_autoneg_able;                             // see (RULE5)
        end
    end

    // ==========================================================
    // Next-page words and toggle bits.
    logic [15:0] np_tx_reg, np_rx_reg;
    logic tx_toggle_reg;
    wire [15:0] lane_mask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
    wire [15:0] tx_wmask = NP_TX_WMASK & lane_mask;
    wire [15:0] np_tx_next = wr_np_tx ? ((np_tx_reg & ~tx_wmask) | (wdata[15:0] & tx_wmask)) :
                             np_tx_reg;                               // see (RULE6) see (RULE8) see (RULE22)

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            np_tx_reg <= NP_TX_RESET;
            np_rx_reg <= NP_RX_RESET;
            tx_toggle_reg <= 1'b0;
        end else begin
            np_tx_reg <= np_tx_next;
            if (page_received) begin
                np_rx_reg <= rx_page_word;                            // see (RULE9) see (RULE7)
            end
            if (tx_page_sent) begin
                tx_toggle_reg <= ~tx_toggle_reg;                      // see (RULE7)
            end
        end
    end

    // ==========================================================
    // Role and test control.
    logic [2:0] test_reg;
    logic [4:0] role_reg;
    logic man_master_reg, multiport_reg;
    wire [7:0] ctl_lane = wstrb[1] ? wdata[15:8] : {test_reg, role_reg};
    wire [2:0] test_wr = ctl_lane[7:5];
    wire [2:0] test_next = !wr_ctl ? test_reg :
                           (test_wr > TEST_DISTORTION) ? TEST_NORMAL : test_wr;   // see (RULE11)
    wire [4:0] role_next = strap_load ? strap_value :                            // see (RULE18)
                           wr_ctl ? ctl_lane[4:0] : role_reg;         // see (RULE13) see (RULE16) see (RULE17)
    wire en_next = role_next[CTL_MAN_EN_BIT - CTL_HD_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_reg <= TEST_MODE_RESET;
            role_reg <= ROLE_ADV_RESET;
            man_master_reg <= 1'b0;
            multiport_reg <= 1'b0;
        end else begin
            test_reg <= test_next;
            role_reg <= role_next;
            man_master_reg <= role_next[CTL_MAN_VAL_BIT - CTL_HD_BIT] & ~en_next;   // see (RULE14)
            multiport_reg <= role_next[CTL_PORT_BIT - CTL_HD_BIT] & ~en_next;       // see (RULE15)
        end
    end

    // ==========================================================
    // Read data.
    wire [15:0] exp_word = {11'h000, pd_fault_reg, lp_np_reg, NP_ABLE_LOCAL,
                            page_rx_reg, lp_an_reg};                  // see (RULE3) see (RULE19)
    wire [15:0] tx_word = {np_tx_reg[NP_NEXT_BIT], 1'b0, np_tx_reg[NP_MSG_BIT:NP_ACK2_BIT],
                           tx_toggle_reg, np_tx_reg[NP_CODE_MSB:0]};  // see (RULE10)
    wire [15:0] ctl_word = {test_reg, role_reg, 8'h00};
    wire [15:0] rd_word = !ra_high_zero ? 16'h0000 :
                          (ra == ADDR_EXPANSION) ? exp_word :
                          (ra == ADDR_NP_TX) ? tx_word :
                          (ra == ADDR_NP_RX) ? np_rx_reg :
                          (ra == ADDR_ROLE_TEST) ? ctl_word : 16'h0000;   // see (RULE22)

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h00000000;
        end else if (rd_take) begin
            rdata_reg <= {16'h0000, rd_word};
        end
    end

    // ==========================================================
    // Outputs.
    assign awready = awready_reg;
    assign wready = awready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign tx_page_word = tx_word;
    assign test_mode = test_reg;
    assign manual_enable = role_reg[CTL_MAN_EN_BIT - CTL_HD_BIT];
    assign manual_master = man_master_reg;
    assign multiport = multiport_reg;
    assign adv_1000_fd = role_reg[CTL_FD_BIT - CTL_HD_BIT];
    assign adv_1000_hd = role_reg[CTL_HD_BIT - CTL_HD_BIT];
    assign lp_ability_valid = page_rx_reg;                            // see (RULE20)

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    pd_fault_latch_a: assert property (par_det_fault |=> pd_fault_reg)  // see (RULE1)
        else $error("fault not latched");
    latch_hold_a: assert property (pd_fault_reg && !rd_exp |=> pd_fault_reg)  // see (RULE21)
        else $error("latched fault lost without read");
    page_clear_a: assert property (page_rx_reg && rd_exp && !page_received |=> !page_rx_reg)  // see (RULE21)
        else $error("page flag not cleared by read");
    exp_read_a: assert property (rd_exp |=> rdata[EXP_PAGE_RX_BIT] == $past(page_rx_reg) &&
                                  rdata[EXP_NP_ABLE_BIT] == NP_ABLE_LOCAL)  // see (RULE4)
        else $error("expansion read wrong");
    rx_capture_a: assert property (page_received |=> np_rx_reg == $past(rx_page_word))  // see (RULE9)
        else $error("received page not captured");
    toggle_flip_a: assert property (tx_page_sent |=> tx_page_word[NP_TOGGLE_BIT] != $past(tx_page_word[NP_TOGGLE_BIT]))  // see (RULE7)
        else $error("toggle did not flip");
    code_write_a: assert property (wr_np_tx && wstrb[1:0] == 2'h3 |=> tx_page_word[10:0] == $past(wdata[10:0]))  // see (RULE8)
        else $error("code field not written");
    strap_default_a: assert property (strap_load |=> role_reg == $past(strap_value) ##1 strap_done_reg)  // see (RULE18)
        else $error("strap default not loaded");
    test_legal_a: assert property (test_mode <= TEST_DISTORTION)  // see (RULE11)
        else $error("reserved test mode active");
    upper_zero_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)  // see (RULE22)
        else $error("upper read bits not zero");
    write_resp_a: assert property (wr_take |=> bvalid && !awready)
        else $error("write response missing");

    write_seen_c: cover property (wr_np_tx ##[1:4] bvalid && bready);
    fault_read_c: cover property (pd_fault_reg && rd_exp);
    page_rx_c: cover property (page_received ##[1:8] rd_exp);
    strap_load_c: cover property (strap_load && strap_value == STRAP_MODE2);

endmodule

// ==== shared/autoneg_regs_pkg.sv ====
package autoneg_regs_pkg;

    // ==========================================================
    // Register indices and byte addresses (index times four).
    localparam int unsigned IDX_EXPANSION = 6;
    localparam int unsigned IDX_NP_TX = 7;
    localparam int unsigned IDX_NP_RX = 8;
    localparam int unsigned IDX_ROLE_TEST = 9;
    localparam logic [7:0] ADDR_EXPANSION = 8'(IDX_EXPANSION * 4);
    localparam logic [7:0] ADDR_NP_TX = 8'(IDX_NP_TX * 4);
    localparam logic [7:0] ADDR_NP_RX = 8'(IDX_NP_RX * 4);
    localparam logic [7:0] ADDR_ROLE_TEST = 8'(IDX_ROLE_TEST * 4);

    // ==========================================================
    // Field positions.
    localparam int unsigned EXP_PD_FAULT_BIT = 4;
    localparam int unsigned EXP_LP_NP_BIT = 3;
    localparam int unsigned EXP_NP_ABLE_BIT = 2;
    localparam int unsigned EXP_PAGE_RX_BIT = 1;
    localparam int unsigned EXP_LP_AN_BIT = 0;
    localparam int unsigned NP_NEXT_BIT = 15;
    localparam int unsigned NP_ACK_BIT = 14;
    localparam int unsigned NP_MSG_BIT = 13;
    localparam int unsigned NP_ACK2_BIT = 12;
    localparam int unsigned NP_TOGGLE_BIT = 11;
    localparam int unsigned NP_CODE_MSB = 10;
    localparam int unsigned CTL_TEST_MSB = 15;
    localparam int unsigned CTL_TEST_LSB = 13;
    localparam int unsigned CTL_MAN_EN_BIT = 12;
    localparam int unsigned CTL_MAN_VAL_BIT = 11;
    localparam int unsigned CTL_PORT_BIT = 10;
    localparam int unsigned CTL_FD_BIT = 9;
    localparam int unsigned CTL_HD_BIT = 8;

    // ==========================================================
    // Reset values and writable masks.
    localparam logic [15:0] NP_TX_RESET = 16'h2001;
    localparam logic [15:0] NP_RX_RESET = 16'h2000;
    localparam logic [15:0] NP_TX_WMASK = 16'hB7FF;
    localparam logic [2:0] TEST_MODE_RESET = 3'h0;
    localparam logic [4:0] ROLE_ADV_RESET = 5'h00;

    // ==========================================================
    // Test mode codes; codes above the distortion test are reserved.
    localparam logic [2:0] TEST_NORMAL = 3'h0;
    localparam logic [2:0] TEST_WAVEFORM = 3'h1;
    localparam logic [2:0] TEST_JITTER_MASTER = 3'h2;
    localparam logic [2:0] TEST_JITTER_SLAVE = 3'h3;
    localparam logic [2:0] TEST_DISTORTION = 3'h4;

    // ==========================================================
    // Strap defaults for bits 12:8, indexed by the mode pins.
    localparam logic [4:0] STRAP_MODE0 = 5'h03;
    localparam logic [4:0] STRAP_MODE1 = 5'h02;
    localparam logic [4:0] STRAP_MODE2 = 5'h1F;
    localparam logic [4:0] STRAP_MODE3 = 5'h13;
    localparam logic [1:0] STRAP_LOAD_CYCLE = 2'h2;

    // ==========================================================
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== verification/an_link_partner.sv ====
`timescale 1ns/1ns
// ==========================================================
// Remote negotiating partner: page events and ability levels.
module an_link_partner (
    input wire logic clk,            // Clock.
    output logic par_det_fault,      // Fault pulse.
    output logic lp_next_page_able,  // Next-page ability level.
    output logic lp_autoneg_able,    // Negotiation ability level.
    output logic page_received,      // New page pulse.
    output logic [15:0] rx_page_word, // Page word.
    output logic tx_page_sent        // Local page sent pulse.
);
    initial begin
        par_det_fault <= 1'b0;
        lp_next_page_able <= 1'b0;
        lp_autoneg_able <= 1'b0;
        page_received <= 1'b0;
        rx_page_word <= 16'h5A5A;
        tx_page_sent <= 1'b0;
    end

    task automatic set_ability(input logic np, input logic an);
        @(posedge clk);
        lp_next_page_able <= np;
        lp_autoneg_able <= an;
    endtask

    // The word is only valid with the pulse; afterwards it is inverted.
    task automatic send_page(input logic [15:0] w);
        @(posedge clk);
        rx_page_word <= w;
        page_received <= 1'b1;
        @(posedge clk);
        page_received <= 1'b0;
        rx_page_word <= ~w;
    endtask

    task automatic pulse(input bit fault);
        @(posedge clk);
        if (fault) par_det_fault <= 1'b1;
        else tx_page_sent <= 1'b1;
        @(posedge clk);
        par_det_fault <= 1'b0;
        tx_page_sent <= 1'b0;
    endtask
endmodule

// ==== verification/autoneg_nextpage_msctl_regs_tb.sv ====
`timescale 1ns/1ns
`define CHK(g, e) chk(32'(g), 32'(e))
module autoneg_nextpage_msctl_regs_tb
    import autoneg_regs_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, mode_config_pins;
    logic [31:0] rdata;
    logic par_det_fault, lp_next_page_able, lp_autoneg_able, page_received, tx_page_sent;
    logic [15:0] rx_page_word, tx_page_word;
    logic [2:0] test_mode, m;
    logic manual_enable, manual_master, multiport, adv_1000_fd, adv_1000_hd, lp_ability_valid;
    logic [4:0] s;
    logic [4:0] strap_tbl [4] = '{STRAP_MODE0, STRAP_MODE1, STRAP_MODE2, STRAP_MODE3};
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;

    autoneg_nextpage_msctl_regs DUT (
        .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .mode_config_pins(mode_config_pins), .par_det_fault(par_det_fault),
        .lp_next_page_able(lp_next_page_able), .lp_autoneg_able(lp_autoneg_able),
        .page_received(page_received), .rx_page_word(rx_page_word), .tx_page_sent(tx_page_sent),
        .tx_page_word(tx_page_word), .test_mode(test_mode), .manual_enable(manual_enable),
        .manual_master(manual_master), .multiport(multiport), .adv_1000_fd(adv_1000_fd),
        .adv_1000_hd(adv_1000_hd), .lp_ability_valid(lp_ability_valid)
    );

    an_link_partner u_lp (
        .clk(clk), .par_det_fault(par_det_fault), .lp_next_page_able(lp_next_page_able),
        .lp_autoneg_able(lp_autoneg_able), .page_received(page_received),
        .rx_page_word(rx_page_word), .tx_page_sent(tx_page_sent)
    );

    always #25 clk = ~clk;

    // ==========================================================
    // Checking and closing.
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic close_out();
        $display("Checks: %0d, mismatches: %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    // ==========================================================
    // Register bus master.
    task automatic wrc(input logic [7:0] a, input logic [15:0] d, input logic [3:0] st,
                       input logic [1:0] er);
        bit aw_d;
        bit w_d;
        aw_d = 0;
        w_d = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {16'hA5A5, d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge clk);
            if (awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_d = 1;
            end
            if (wready === 1'b1) begin
                wvalid <= 1'b0;
                w_d = 1;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        bready <= 1'b0;
        `CHK(bresp, er);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rready <= 1'b0;
        `CHK(rdata, ed);
        `CHK(rresp, er);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // ==========================================================
    // Test sequence.
    initial begin
        {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} <= '0;
        wdata <= '0;
        wstrb <= '0;
        mode_config_pins <= 2'h0;
        for (int p = 0; p < 4; p++) begin
            mode_config_pins <= 2'(p);
            s = strap_tbl[p];
            do_reset();
            rdc(ADDR_ROLE_TEST, {19'h0, s, 8'h00}, RESP_OKAY);
            `CHK({manual_enable, manual_master, multiport}, {s[4], s[3] & ~s[4], s[2] & ~s[4]});
        end
        rdc(ADDR_NP_TX, 32'h2001, RESP_OKAY);
        `CHK(tx_page_word, 16'h2001);
        rdc(ADDR_NP_RX, 32'h2000, RESP_OKAY);
        rdc(ADDR_EXPANSION, 32'h0, RESP_OKAY);
        for (int c = 0; c < 8; c++) begin
            m = (c < 5) ? 3'(c) : 3'h0;
            wrc(ADDR_ROLE_TEST, {3'(c), 13'h00FF}, 4'hF, RESP_OKAY);
            `CHK(test_mode, m);
            rdc(ADDR_ROLE_TEST, {16'h0, m, 13'h0}, RESP_OKAY);
        end
        wrc(ADDR_ROLE_TEST, 16'h0C00, 4'hF, RESP_OKAY);
        `CHK({manual_enable, manual_master, multiport}, 3'b011);
        wrc(ADDR_ROLE_TEST, 16'h1C00, 4'hF, RESP_OKAY);
        `CHK({manual_enable, manual_master, multiport}, 3'b100);
        rdc(ADDR_ROLE_TEST, 32'h1C00, RESP_OKAY);
        wrc(ADDR_ROLE_TEST, 16'h0200, 4'hF, RESP_OKAY);
        `CHK({adv_1000_fd, adv_1000_hd}, 2'b10);
        wrc(ADDR_ROLE_TEST, 16'h0100, 4'hF, RESP_OKAY);
        `CHK({adv_1000_fd, adv_1000_hd}, 2'b01);
        wrc(ADDR_ROLE_TEST, 16'hE000, 4'h1, RESP_OKAY);
        `CHK(test_mode, TEST_NORMAL);
        rdc(ADDR_ROLE_TEST, 32'h0100, RESP_OKAY);
        wrc(ADDR_NP_TX, 16'hFFFF, 4'hF, RESP_OKAY);
        rdc(ADDR_NP_TX, 32'hB7FF, RESP_OKAY);
        u_lp.pulse(1'b0);
        rdc(ADDR_NP_TX, 32'hBFFF, RESP_OKAY);
        wrc(ADDR_NP_TX, 16'h0000, 4'h1, RESP_OKAY);
        rdc(ADDR_NP_TX, 32'hBF00, RESP_OKAY);
        wrc(ADDR_NP_TX, 16'h1005, 4'hF, RESP_OKAY);
        `CHK(tx_page_word, 16'h1805);
        u_lp.set_ability(1'b1, 1'b1);
        u_lp.send_page(16'hD8AB);
        u_lp.pulse(1'b1);
        `CHK(lp_ability_valid, 1'b1);
        rdc(ADDR_EXPANSION, 32'h1B, RESP_OKAY);
        rdc(ADDR_NP_RX, 32'hD8AB, RESP_OKAY);
        rdc(ADDR_EXPANSION, 32'h09, RESP_OKAY);
        `CHK(lp_ability_valid, 1'b0);
        wrc(ADDR_EXPANSION, 16'hFFFF, 4'hF, RESP_OKAY);
        wrc(ADDR_NP_RX, 16'h0000, 4'hF, RESP_OKAY);
        rdc(ADDR_NP_RX, 32'hD8AB, RESP_OKAY);
        u_lp.set_ability(1'b0, 1'b0);
        u_lp.send_page(16'h2800);
        rdc(ADDR_NP_RX, 32'h2800, RESP_OKAY);
        rdc(ADDR_EXPANSION, 32'h02, RESP_OKAY);
        wrc(8'h28, 16'hFFFF, 4'hF, RESP_SLVERR);
        rdc(8'h28, 32'h0, RESP_SLVERR);
        close_out();
    end
endmodule
